// ### adpc_host.sv
/*
  Host bus controller model driving the converter pins.
  Assumes its tasks are called from the bench; pins move on falling edges.
*/
`timescale 1ns/1ns
module adpc_host
(
  // Clock
  input wire logic        clk,
  // Pins to the converter
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            conv_start_n,
  output logic            power_down_n,
  output logic            mode_sel_hi,
  output logic            mode_sel_lo,
  output logic            gain_select,
  output logic            polarity_select,
  output logic            input_pairing,
  output logic [2:0]      channel_sel,
  // Bus and status from the converter
  input wire logic        busy_n,
  input wire logic        bus_oe_n,
  input wire logic [11:0] data_out,
  input wire logic [2:0]  channel_echo,
  input wire logic        pairing_echo
);
  initial
  begin
    {cs_n, rd_n, wr_n, conv_start_n, power_down_n} = 5'h1F;
    {mode_sel_hi, mode_sel_lo} = 2'h0;
    {input_pairing, channel_sel, polarity_select, gain_select} = 6'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic set_ctl(input logic cs, input logic wr, input logic pd);
    {cs_n, wr_n, power_down_n} = {cs, wr, pd};
  endtask : set_ctl

  task automatic cfg(input logic [6:0] e);
    {input_pairing, channel_sel, polarity_select, gain_select} = e[6:1];
  endtask : cfg

  task automatic mode(input logic [1:0] m);
    {mode_sel_hi, mode_sel_lo} = m;
    tick(6);
  endtask : mode

  // The end-of-sequence flag rides on the start pin while writing entries.
  task automatic load(input logic last);
    conv_start_n = last;
    wr_n = 1'h0;
    tick(4);
    wr_n = 1'h1;
    tick(4);
    conv_start_n = 1'h1;
  endtask : load

  task automatic convert(output logic ok);
    logic low_seen;
    conv_start_n = 1'h0;
    tick(5);
    low_seen = (busy_n === 1'h0);
    conv_start_n = 1'h1;
    for (int n = 0; n < 200 && busy_n !== 1'h1; n++)
      tick(1);
    ok = low_seen && (busy_n === 1'h1);
  endtask : convert

  task automatic read(output logic [15:0] w, output logic oe);
    rd_n = 1'h0;
    tick(4);
    oe = (bus_oe_n === 1'h0);
    // An undriven bus must not look valid, so it reads inverted.
    w = oe ? {pairing_echo, channel_echo, data_out} : ~{pairing_echo, channel_echo, data_out};
    rd_n = 1'h1;
    tick(4);
  endtask : read
endmodule : adpc_host

// ### adpc_pkg.sv
/*
  Constants and types for the converter control sequencer.
  Assumes a single 50 MHz clock and a host that drives the pins asynchronously.
*/
package adpc_pkg;

  localparam int CLK_PERIOD_NS  = 20;
  localparam int CONV_TIME_NS   = 2000;
  // Longest time, so the count rounds down.
  localparam int CONV_CYCLES    = (CONV_TIME_NS / CLK_PERIOD_NS < 1) ? 1
                                  : CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_CNT_W     = 8;

  localparam int RES_W          = 12;
  localparam int CH_W           = 3;
  localparam int SEQ_DEPTH      = 16;
  localparam int SEQ_AW         = 4;
  localparam int ENTRY_W        = 7;
  localparam int PIN_W          = 13;

  // Sequencer entry fields.
  localparam int SEQ_PAIR_BIT   = 6;
  localparam int SEQ_CH_LSB     = 3;
  localparam int SEQ_POL_BIT    = 2;
  localparam int SEQ_GAIN_BIT   = 1;
  localparam int SEQ_LAST_BIT   = 0;
  localparam int RB_LSB         = 9;

  // Synchronised pin vector layout.
  localparam int PIN_CS         = 0;
  localparam int PIN_RD         = 1;
  localparam int PIN_WR         = 2;
  localparam int PIN_CONV       = 3;
  localparam int PIN_PD         = 4;
  localparam int PIN_MHI        = 5;
  localparam int PIN_MLO        = 6;
  localparam int PIN_GAIN       = 7;
  localparam int PIN_POL        = 8;
  localparam int PIN_PAIR       = 9;
  localparam int PIN_CH_LSB     = 10;

  // Reset levels: strobes idle high, configuration low.
  localparam logic [PIN_W-1:0] PIN_RST = 13'h001F;
  localparam logic [ENTRY_W-1:0] ENTRY_RST = 7'h00;
  localparam logic [RES_W-1:0] RES_RST = 12'h000;
  localparam logic [SEQ_AW-1:0] PTR_FIRST = 4'h0;

  // Mode codes {high select, low select}.
  localparam logic [1:0] MODE_DIRECT = 2'h0;
  localparam logic [1:0] MODE_SCAN   = 2'h1;
  localparam logic [1:0] MODE_PROG   = 2'h2;
  localparam logic [1:0] MODE_SEQ    = 2'h3;

  typedef enum logic [0:0] {ADPC_IDLE, ADPC_CONV} adpc_state_t;

endpackage : adpc_pkg

// ### adpc_seq_mem.sv
/*
  Sequencer entry memory: one write port and a registered read port.
  Assumes the read address is held steady for a cycle before the data is used.
*/
`timescale 1ns/1ns
module adpc_seq_mem
  import adpc_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  // Write port
  input  wire logic               wr_en,
  input  wire logic [SEQ_AW-1:0]  wr_addr,
  input  wire logic [ENTRY_W-1:0] wr_data,
  // Read port
  input  wire logic [SEQ_AW-1:0]  rd_addr,
  output logic      [ENTRY_W-1:0] rd_data
);

  logic [ENTRY_W-1:0] mem [SEQ_DEPTH];

  // Contents have no reset; only the read register does.
  always_ff @(posedge clk)
  begin
    if (clk_en && wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_data <= ENTRY_RST;
    end
    else if (clk_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : adpc_seq_mem

// ### adpc_sync.sv
/*
  Two-stage synchroniser for a vector of asynchronous pin levels.
  Assumes each bit is an independent level; no word coherence is promised.
*/
`timescale 1ns/1ns
module adpc_sync
#(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q   <= RST;
      sync_out <= RST;
    end
    else if (clk_en)
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : adpc_sync

// ### adpc_top.sv
/*
  Control and output logic of the eight-channel sampling converter.
  Assumes the analog core returns a sample on the same clock and that host pins
  are asynchronous; they are synchronised before use.
*/
`timescale 1ns/1ns
module adpc_top
  import adpc_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     clk_en,
  // Host strobes
  input  wire logic                     cs_n,
  input  wire logic                     rd_n,
  input  wire logic                     wr_n,
  input  wire logic                     conv_start_n,
  input  wire logic                     power_down_n,
  // Mode selects
  input  wire logic                     mode_sel_hi,
  input  wire logic                     mode_sel_lo,
  // Channel and configuration inputs
  input  wire logic                     gain_select,
  input  wire logic                     polarity_select,
  input  wire logic                     input_pairing,
  input  wire logic [adpc_pkg::CH_W-1:0] channel_sel,
  // Analog core sample
  input  wire logic [adpc_pkg::RES_W-1:0] adc_sample,
  // Three-state output bus
  output logic      [adpc_pkg::RES_W-1:0] data_out,
  output logic      [adpc_pkg::CH_W-1:0]  channel_echo,
  output logic                          pairing_echo,
  output logic                          bus_oe_n,
  output logic                          busy_n,
  // Analog core controls
  output logic      [adpc_pkg::CH_W-1:0]  mux_channel,
  output logic                          mux_pairing,
  output logic                          shared_neg_input,
  output logic                          gain_one,
  output logic                          bipolar_span,
  output logic                          sample_hold,
  output logic                          nap_mode,
  output logic                          sleep_mode
);

  import adpc_pkg::*;

  logic [PIN_W-1:0]   pin_raw;
  logic [PIN_W-1:0]   pin_s;
  logic [PIN_W-1:0]   pin_prev_q;
  logic [ENTRY_W-1:0] mem_rd;

  assign pin_raw = {channel_sel, input_pairing, polarity_select, gain_select,
                    mode_sel_lo, mode_sel_hi, power_down_n, conv_start_n,
                    wr_n, rd_n, cs_n};

  adpc_sync #(.W(PIN_W), .RST(PIN_RST)) u_sync
  (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );

  // Decoded synchronised pins.
  logic               cs_act;
  logic               rd_act;
  logic               wr_low;
  logic               wr_rise;
  logic               rd_rise;
  logic               conv_fall;
  logic [1:0]         mode;
  logic [ENTRY_W-1:0] pin_entry;

  always_comb
  begin
    cs_act    = ~pin_s[PIN_CS];
    rd_act    = ~pin_s[PIN_RD] & cs_act;
    wr_low    = ~pin_s[PIN_WR];
    wr_rise   = pin_s[PIN_WR] & ~pin_prev_q[PIN_WR];
    rd_rise   = pin_s[PIN_RD] & ~pin_prev_q[PIN_RD] & cs_act;
    conv_fall = ~pin_s[PIN_CONV] & pin_prev_q[PIN_CONV] & cs_act;
    mode      = {pin_s[PIN_MHI], pin_s[PIN_MLO]};
    pin_entry = {pin_s[PIN_PAIR], pin_s[PIN_CH_LSB +: CH_W], pin_s[PIN_POL],
                 pin_s[PIN_GAIN], 1'b0};
  end

  // Main state.
  adpc_state_t        state_q,     state_d;
  logic [CONV_CNT_W-1:0] cnt_q,    cnt_d;
  logic [ENTRY_W-1:0] cfg_q,       cfg_d;
  logic [ENTRY_W-1:0] conv_cfg_q,  conv_cfg_d;
  logic [CH_W-1:0]    scan_ch_q,   scan_ch_d;
  logic [SEQ_AW-1:0]  ptr_q,       ptr_d;
  logic [1:0]         mode_q,      mode_d;
  logic [RES_W-1:0]   res_q,       res_d;
  logic [CH_W-1:0]    res_ch_q,    res_ch_d;
  logic               res_pair_q,  res_pair_d;
  logic [RES_W-1:0]   data_d;
  logic [CH_W-1:0]    ch_echo_d;
  logic               pair_echo_d;
  logic               oe_n_d;
  logic               busy_n_d;
  logic               nap_d;
  logic               sleep_d;
  logic               mem_we;
  logic               shut;
  logic               run_cfg_last;
  logic [ENTRY_W-1:0] start_cfg;

  always_comb
  begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    cfg_d       = cfg_q;
    conv_cfg_d  = conv_cfg_q;
    scan_ch_d   = scan_ch_q;
    ptr_d       = ptr_q;
    mode_d      = mode;
    res_d       = res_q;
    res_ch_d    = res_ch_q;
    res_pair_d  = res_pair_q;
    mem_we      = 1'b0;
    shut        = ~pin_s[PIN_PD];
    nap_d       = shut & cs_act;
    sleep_d     = shut & ~cs_act;
    run_cfg_last = 1'b0;
    start_cfg   = cfg_q;

    // Direct-address and scan configuration follows the pins while the load
    // strobe is low and freezes when it rises, so tying it low is transparent.
    if ((mode == MODE_DIRECT || mode == MODE_SCAN) && wr_low)
    begin
      cfg_d = pin_entry;
    end

    // Location restarts on every entry into program/read-back mode.
    if (mode == MODE_PROG && mode_q != MODE_PROG)
    begin
      ptr_d = PTR_FIRST;
    end
    else if (mode == MODE_PROG && state_q == ADPC_IDLE)
    begin
      if (wr_rise)
      begin
        mem_we = 1'b1;
        ptr_d  = ptr_q + 1'b1;
      end
      else if (rd_rise)
      begin
        ptr_d = ptr_q + 1'b1;
      end
    end

    // Choose the configuration used by the next conversion.
    unique case (mode)
      MODE_SCAN:
      begin
        start_cfg = {cfg_q[SEQ_PAIR_BIT], scan_ch_q, cfg_q[SEQ_POL_BIT:0]};
      end
      MODE_SEQ:
      begin
        start_cfg    = mem_rd;
        run_cfg_last = mem_rd[SEQ_LAST_BIT];
      end
      default:
      begin
        start_cfg = cfg_d;
      end
    endcase

    unique case (state_q)
      ADPC_IDLE:
      begin
        // Starts are refused while shut down or in program mode.
        if (conv_fall && !shut && mode != MODE_PROG)
        begin
          state_d    = ADPC_CONV;
          cnt_d      = CONV_CNT_W'(CONV_CYCLES - 1);
          conv_cfg_d = start_cfg;
          if (mode == MODE_SCAN)
          begin
            // Paired inputs step over the partner channel.
            scan_ch_d = start_cfg[SEQ_PAIR_BIT] ? scan_ch_q + 3'h2
                                                : scan_ch_q + 3'h1;
          end
          if (mode == MODE_SEQ)
          begin
            ptr_d = run_cfg_last ? PTR_FIRST : ptr_q + 1'b1;
          end
        end
      end
      ADPC_CONV:
      begin
        if (cnt_q == '0)
        begin
          state_d    = ADPC_IDLE;
          res_d      = adc_sample;
          res_ch_d   = conv_cfg_q[SEQ_CH_LSB +: CH_W];
          res_pair_d = conv_cfg_q[SEQ_PAIR_BIT];
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
    endcase

    busy_n_d = ~(state_d == ADPC_CONV || mode == MODE_PROG);

    // Output bus contents.
    if (mode == MODE_PROG)
    begin
      data_d      = {mem_rd[SEQ_POL_BIT:0], 9'h000};
      ch_echo_d   = mem_rd[SEQ_CH_LSB +: CH_W];
      pair_echo_d = mem_rd[SEQ_PAIR_BIT];
    end
    else
    begin
      data_d      = res_d;
      ch_echo_d   = res_ch_d;
      pair_echo_d = res_pair_d;
    end
    oe_n_d = ~rd_act;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q      <= ADPC_IDLE;
      cnt_q        <= '0;
      cfg_q        <= ENTRY_RST;
      conv_cfg_q   <= ENTRY_RST;
      scan_ch_q    <= '0;
      ptr_q        <= PTR_FIRST;
      mode_q       <= MODE_DIRECT;
      res_q        <= RES_RST;
      res_ch_q     <= '0;
      res_pair_q   <= 1'b0;
      pin_prev_q   <= PIN_RST;
      data_out     <= RES_RST;
      channel_echo <= '0;
      pairing_echo <= 1'b0;
      bus_oe_n     <= 1'b1;
      busy_n       <= 1'b1;
      nap_mode     <= 1'b0;
      sleep_mode   <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      cfg_q        <= cfg_d;
      conv_cfg_q   <= conv_cfg_d;
      scan_ch_q    <= scan_ch_d;
      ptr_q        <= ptr_d;
      mode_q       <= mode_d;
      res_q        <= res_d;
      res_ch_q     <= res_ch_d;
      res_pair_q   <= res_pair_d;
      pin_prev_q   <= pin_s;
      data_out     <= data_d;
      channel_echo <= ch_echo_d;
      pairing_echo <= pair_echo_d;
      bus_oe_n     <= oe_n_d;
      busy_n       <= busy_n_d;
      nap_mode     <= nap_d;
      sleep_mode   <= sleep_d;
    end
  end

  // Analog core controls follow the conversion configuration while converting and the latched pin configuration otherwise.
  logic [ENTRY_W-1:0] mux_cfg;

  always_comb
  begin
    mux_cfg = (state_d == ADPC_CONV) ? conv_cfg_d : cfg_d;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mux_channel      <= '0;
      mux_pairing      <= 1'b0;
      shared_neg_input <= 1'b1;
      gain_one         <= 1'b0;
      bipolar_span     <= 1'b0;
      sample_hold      <= 1'b0;
    end
    else if (clk_en)
    begin
      mux_channel      <= mux_cfg[SEQ_CH_LSB +: CH_W];
      mux_pairing      <= mux_cfg[SEQ_PAIR_BIT];
      shared_neg_input <= ~mux_cfg[SEQ_PAIR_BIT];
      gain_one         <= mux_cfg[SEQ_GAIN_BIT];
      bipolar_span     <= mux_cfg[SEQ_POL_BIT];
      sample_hold      <= (state_d == ADPC_CONV);
    end
  end

  // The end-of-sequence flag has no pin of its own, so it rides on the start
  // pin level; starts are refused in program mode, so that pin is free while
  // entries are written.
  logic [ENTRY_W-1:0] wr_entry;

  always_comb
  begin
    wr_entry = {pin_entry[ENTRY_W-1:1], pin_s[PIN_CONV]};
  end

  adpc_seq_mem u_mem
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .wr_en   (mem_we),
    .wr_addr (ptr_q),
    .wr_data (wr_entry),
    .rd_addr (ptr_d),
    .rd_data (mem_rd)
  );

endmodule : adpc_top

// ### adpc_top_asserts.sv
/*
  Port-level checks of the converter control block, bound into adpc_top.
  Assumes pins change away from the rising clock edge; checks pause while clk_en is low.
*/
`timescale 1ns/1ns
module adpc_top_asserts
  import adpc_pkg::*;
(
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire logic                        clk_en,
  // Host pins and analog core sample
  input wire logic                        cs_n,
  input wire logic                        rd_n,
  input wire logic                        conv_start_n,
  input wire logic                        power_down_n,
  input wire logic                        mode_sel_hi,
  input wire logic                        mode_sel_lo,
  input wire logic [adpc_pkg::RES_W-1:0]  adc_sample,
  // Bus and status
  input wire logic [adpc_pkg::RES_W-1:0]  data_out,
  input wire logic [adpc_pkg::CH_W-1:0]   channel_echo,
  input wire logic                        pairing_echo,
  input wire logic                        bus_oe_n,
  input wire logic                        busy_n,
  // Analog core controls
  input wire logic [adpc_pkg::CH_W-1:0]   mux_channel,
  input wire logic                        mux_pairing,
  input wire logic                        shared_neg_input,
  input wire logic                        sample_hold,
  input wire logic                        nap_mode,
  input wire logic                        sleep_mode
);
  logic [7:0] hold_cnt_q;
  logic [7:0] hold_cnt_d;

  // The hold time is too long for a repetition, so it is counted here.
  always_comb hold_cnt_d = sample_hold ? hold_cnt_q + 8'h01 : 8'h00;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      hold_cnt_q <= 8'h00;
    else if (clk_en)
      hold_cnt_q <= hold_cnt_d;

  default clocking cb @(posedge clk); endclocking
  // A frozen block shows no latency, so every check stands aside meanwhile.
  default disable iff (sys_rst || !clk_en);

  property p_conv_len;
    $fell(sample_hold) |-> hold_cnt_q == 8'(CONV_CYCLES);
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");
  property p_busy_conv;
    sample_hold |-> !busy_n;
  endproperty
  a_busy_conv: assert property (p_busy_conv)
    else $error("busy high during conversion");
  property p_busy_prog;
    (mode_sel_hi && !mode_sel_lo) [*5] |-> !busy_n;
  endproperty
  a_busy_prog: assert property (p_busy_prog)
    else $error("busy high in program mode");
  property p_oe_cause;
    !bus_oe_n |-> !$past(rd_n, 3) && !$past(cs_n, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("bus driven without read and select");
  property p_oe_on;
    (!rd_n && !cs_n) [*4] |-> !bus_oe_n;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("bus not driven during read");
  property p_start_cause;
    $rose(sample_hold) |-> $past(!conv_start_n && !cs_n, 2);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("conversion without selected start");
  property p_mux_hold;
    sample_hold && $past(sample_hold) |-> $stable(mux_channel) && $stable(mux_pairing);
  endproperty
  a_mux_hold: assert property (p_mux_hold)
    else $error("channel moved during conversion");
  property p_result;
    $rose(busy_n) && $past(sample_hold) |-> channel_echo == $past(mux_channel)
      && pairing_echo == $past(mux_pairing) && data_out == $past(adc_sample);
  endproperty
  a_result: assert property (p_result)
    else $error("result word wrong at busy rise");
  property p_shared;
    shared_neg_input == !mux_pairing;
  endproperty
  a_shared: assert property (p_shared)
    else $error("shared input enable wrong");
  property p_nap;
    (!power_down_n && !cs_n) [*4] |-> nap_mode && !sleep_mode;
  endproperty
  a_nap: assert property (p_nap)
    else $error("nap not selected");
  property p_sleep;
    (!power_down_n && cs_n) [*4] |-> sleep_mode && !nap_mode;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep not selected");
endmodule : adpc_top_asserts

bind adpc_top adpc_top_asserts u_adpc_top_asserts (.clk(clk), .sys_rst(sys_rst),
  .clk_en(clk_en), .cs_n(cs_n), .rd_n(rd_n), .conv_start_n(conv_start_n),
  .power_down_n(power_down_n), .mode_sel_hi(mode_sel_hi), .mode_sel_lo(mode_sel_lo),
  .adc_sample(adc_sample), .data_out(data_out), .channel_echo(channel_echo),
  .pairing_echo(pairing_echo), .bus_oe_n(bus_oe_n), .busy_n(busy_n),
  .mux_channel(mux_channel), .mux_pairing(mux_pairing),
  .shared_neg_input(shared_neg_input), .sample_hold(sample_hold), .nap_mode(nap_mode),
  .sleep_mode(sleep_mode));

// ### tb_top.sv
/*
  Self-checking bench for the converter control block.
  Assumes the analog core returns a sample that encodes its mux settings.
*/
`timescale 1ns/1ns
module tb_top;
  import adpc_pkg::*;
  logic clk, sys_rst, clk_en;
  logic cs_n, rd_n, wr_n, conv_start_n, power_down_n, mode_sel_hi, mode_sel_lo;
  logic gain_select, polarity_select, input_pairing, pairing_echo, bus_oe_n, busy_n;
  logic mux_pairing, shared_neg_input, gain_one, bipolar_span, sample_hold;
  logic nap_mode, sleep_mode, ok, oe;
  logic [CH_W-1:0]  channel_sel, channel_echo, mux_channel;
  logic [RES_W-1:0] adc_sample, data_out;
  logic [15:0]      w, w1;
  logic [6:0]       e;
  logic [6:0]       ent [3] = '{7'h34, 7'h52, 7'h0F};
  int               bad_count, n_compared, cycles;

  // The sample carries the mux settings so routing shows in the result.
  assign adc_sample = {mux_pairing, gain_one, bipolar_span, 6'h15, mux_channel};

  adpc_top u_adpc_top (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .conv_start_n(conv_start_n), .power_down_n(power_down_n),
    .mode_sel_hi(mode_sel_hi), .mode_sel_lo(mode_sel_lo), .gain_select(gain_select),
    .polarity_select(polarity_select), .input_pairing(input_pairing),
    .channel_sel(channel_sel), .adc_sample(adc_sample), .data_out(data_out),
    .channel_echo(channel_echo), .pairing_echo(pairing_echo), .bus_oe_n(bus_oe_n),
    .busy_n(busy_n), .mux_channel(mux_channel), .mux_pairing(mux_pairing),
    .shared_neg_input(shared_neg_input), .gain_one(gain_one), .bipolar_span(bipolar_span),
    .sample_hold(sample_hold), .nap_mode(nap_mode), .sleep_mode(sleep_mode));

  adpc_host u_adpc_host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .conv_start_n(conv_start_n), .power_down_n(power_down_n), .mode_sel_hi(mode_sel_hi),
    .mode_sel_lo(mode_sel_lo), .gain_select(gain_select), .polarity_select(polarity_select),
    .input_pairing(input_pairing), .channel_sel(channel_sel), .busy_n(busy_n),
    .bus_oe_n(bus_oe_n), .data_out(data_out), .channel_echo(channel_echo),
    .pairing_echo(pairing_echo));

  function automatic logic [15:0] conv_word(input logic [6:0] x);
    return {x[6], x[5:3], x[6], x[1], x[2], 6'h15, x[5:3]};
  endfunction : conv_word

  task automatic cmp16(input string nm, input logic [15:0] x, input logic [15:0] g);
    n_compared++;
    if (g !== x)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask : cmp16

  task automatic cmp1(input string nm, input logic x, input logic g);
    cmp16(nm, {15'h0000, x}, {15'h0000, g});
  endtask : cmp1

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      bad_count++;
      conclude();
    end
  end

  initial
  begin
    clk_en = 1'h1;
    sys_rst = 1'h1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'h0;
    u_adpc_host.tick(4);
    cmp1("busy_n", 1'h1, busy_n);
    cmp1("bus_oe_n", 1'h1, bus_oe_n);
    $display("test reset done");
    u_adpc_host.set_ctl(1'h0, 1'h0, 1'h1);
    // A selected read would open the bus, unless the enable holds everything still.
    clk_en = 1'h0;
    u_adpc_host.read(w, oe);
    clk_en = 1'h1;
    cmp1("frozen_bus", 1'h0, oe);
    $display("test freeze done");
    for (int i = 0; i < 8; i++)
    begin
      e = {i[0], i[2:0], i[1], i[2], 1'h0};
      u_adpc_host.cfg(e);
      u_adpc_host.tick(4);
      u_adpc_host.convert(ok);
      cmp1("conv_done", 1'h1, ok);
      u_adpc_host.read(w, oe);
      cmp1("bus_on", 1'h1, oe);
      cmp16("direct_word", conv_word(e), w);
    end
    $display("test direct done");
    u_adpc_host.cfg(7'h2A);
    u_adpc_host.tick(4);
    u_adpc_host.set_ctl(1'h0, 1'h1, 1'h1);
    u_adpc_host.tick(4);
    u_adpc_host.cfg(7'h14);
    u_adpc_host.tick(4);
    u_adpc_host.convert(ok);
    u_adpc_host.read(w, oe);
    cmp16("latched_word", conv_word(7'h2A), w);
    $display("test latch done");
    u_adpc_host.set_ctl(1'h1, 1'h0, 1'h1);
    u_adpc_host.convert(ok);
    cmp1("conv_unselected", 1'h0, ok);
    u_adpc_host.read(w, oe);
    cmp1("bus_unselected", 1'h0, oe);
    $display("test deselect done");
    u_adpc_host.set_ctl(1'h0, 1'h0, 1'h1);
    u_adpc_host.cfg(7'h00);
    u_adpc_host.mode(2'h1);
    u_adpc_host.convert(ok);
    u_adpc_host.read(w1, oe);
    cmp16("scan_first", conv_word(7'h00), w1);
    u_adpc_host.convert(ok);
    u_adpc_host.read(w, oe);
    cmp16("scan_step", conv_word(7'h08), w);
    u_adpc_host.cfg(7'h40);
    u_adpc_host.tick(4);
    u_adpc_host.convert(ok);
    u_adpc_host.read(w, oe);
    cmp16("scan_pair", conv_word(7'h50), w);
    u_adpc_host.convert(ok);
    u_adpc_host.read(w, oe);
    cmp16("scan_pair_step", conv_word(7'h60), w);
    $display("test scan done");
    u_adpc_host.set_ctl(1'h0, 1'h1, 1'h1);
    u_adpc_host.mode(2'h2);
    cmp1("busy_prog", 1'h0, busy_n);
    for (int i = 0; i < 3; i++)
    begin
      u_adpc_host.cfg(ent[i]);
      u_adpc_host.load(ent[i][0]);
    end
    u_adpc_host.mode(2'h0);
    u_adpc_host.mode(2'h2);
    u_adpc_host.mode(2'h3);
    cmp1("busy_seq", 1'h1, busy_n);
    for (int k = 0; k < 4; k++)
    begin
      u_adpc_host.convert(ok);
      u_adpc_host.read(w, oe);
      cmp16("seq_word", conv_word(ent[k % 3]), w);
    end
    u_adpc_host.mode(2'h2);
    for (int i = 0; i < 3; i++)
    begin
      u_adpc_host.read(w, oe);
      cmp16("readback", {ent[i][6:0], 9'h000}, w);
    end
    u_adpc_host.mode(2'h0);
    $display("test sequencer done");
    u_adpc_host.set_ctl(1'h0, 1'h1, 1'h0);
    u_adpc_host.tick(6);
    cmp1("nap", 1'h1, nap_mode);
    u_adpc_host.set_ctl(1'h1, 1'h1, 1'h0);
    u_adpc_host.tick(6);
    cmp1("sleep", 1'h1, sleep_mode);
    u_adpc_host.set_ctl(1'h1, 1'h1, 1'h1);
    $display("test power done");
    conclude();
  end
endmodule : tb_top
